// ===== verilog/pmic_cfg_pkg.sv
// constants for the output, clock pin and power-ok configuration bank
package pmic_cfg_pkg;
    // register offsets
    localparam logic [7:0] GEN_OUT_CTRL_ADDR = 8'h12;
    localparam logic [7:0] SETUP_ADDR = 8'h13;
    localparam logic [7:0] EXT_CLK_CTRL_ADDR = 8'h14;
    localparam logic [7:0] POWER_OK_CTRL_ADDR = 8'h15;
    // reset values
    localparam logic [7:0] GEN_OUT_CTRL_RST = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] EXT_CLK_CTRL_RST = 8'h00;
    localparam logic [7:0] POWER_OK_CTRL_RST = 8'h00;
    // writable masks, reserved bits of the output control read zero
    localparam logic [7:0] GEN_OUT_CTRL_WMASK = 8'h77;
    // general output control fields
    localparam int OUT_B_DRIVE_BIT = 6;
    localparam int OUT_B_GATING_BIT = 5;
    localparam int OUT_B_LEVEL_BIT = 4;
    localparam int OUT_A_DRIVE_BIT = 2;
    localparam int OUT_A_GATING_BIT = 1;
    localparam int OUT_A_LEVEL_BIT = 0;
    // setup fields
    localparam int START_STEP_BIT = 6;
    localparam int STOP_STEP_BIT = 5;
    localparam int PIN_FUNCTION_BIT = 4;
    localparam int SHARED_PD_BIT = 3;
    localparam int ENABLE_PD_BIT = 2;
    localparam int THERMAL_LEVEL_BIT = 1;
    localparam int SPREAD_BIT = 0;
    // external clock control fields
    localparam int PLL_ENABLE_BIT = 6;
    localparam int RATE_CODE_MSB = 4;
    localparam int RATE_CODE_LSB = 0;
    localparam logic [4:0] RATE_CODE_MAX = 5'h17;
    // power-ok control fields
    localparam int POK_POLARITY_BIT = 7;
    localparam int POK_DRIVE_BIT = 6;
    localparam int POK_WINDOW_BIT = 4;
    localparam int POK_SRC_B_BIT = 1;
    localparam int POK_SRC_A_BIT = 0;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int DELAY_STEP_NS = 500000;
    localparam int DELAY_STEP_CYCLES =
        (DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== verilog/pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

    always_comb begin
        // a change counts only once stages two and three agree
        out_d = out_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign o_sync = out_q;
endmodule

// ===== verilog/step_delay.sv
// follows an enable level after a coded start-up or shutdown delay
`timescale 1ns/100ps
module step_delay #(
    parameter int STEP_CYCLES = pmic_cfg_pkg::DELAY_STEP_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_target,
    input wire logic [3:0] i_start_code,
    input wire logic [3:0] i_stop_code,
    input wire logic i_start_long,
    input wire logic i_stop_long,
    output logic o_level
);
    localparam int DW = $clog2(STEP_CYCLES + 1);
    typedef enum logic {ST_STEADY, ST_COUNT} state_type;
    state_type state_q, state_d;
    logic [DW-1:0] div_q, div_d;
    logic [4:0] steps_q, steps_d, limit;
    logic level_q, level_d;

    always_comb begin
        // long range doubles the count of half-millisecond steps
        if (i_target) begin
            limit = i_start_long ? {i_start_code, 1'b0} : {1'b0, i_start_code};
        end else begin
            limit = i_stop_long ? {i_stop_code, 1'b0} : {1'b0, i_stop_code};
        end
        state_d = state_q;
        div_d = div_q;
        steps_d = steps_q;
        level_d = level_q;
        case (state_q)
            ST_STEADY: begin
                div_d = '0;
                steps_d = '0;
                if (i_target != level_q) begin
                    if (limit == 5'h00) begin
                        level_d = i_target;
                    end else begin
                        state_d = ST_COUNT;
                    end
                end
            end
            ST_COUNT: begin
                // a reverted enable abandons the pending edge
                if (i_target == level_q) begin
                    state_d = ST_STEADY;
                end else if (div_q == DW'(STEP_CYCLES - 1)) begin
                    div_d = '0;
                    steps_d = steps_q + 5'h01;
                    if (steps_q + 5'h01 >= limit) begin
                        level_d = i_target;
                        state_d = ST_STEADY;
                    end
                end else begin
                    div_d = div_q + DW'(1);
                end
            end
            default: state_d = ST_STEADY;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_q <= ST_STEADY;
            div_q <= '0;
            steps_q <= '0;
            level_q <= 1'b0;
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            steps_q <= steps_d;
            level_q <= level_d;
        end
    end

    assign o_level = level_q;
endmodule

// ===== verilog/pmic_cfg_bank.sv
// configuration bank for general outputs, clock pin, pll and power-ok
// Summary of operation
// - bit 6 picks output b drive: push-pull or open-drain
// - bit 5 gates output b level with the enable pin when set
// - bit 4 sets output b high or low when pin is an output
// - bit 2 picks output a drive: push-pull or open-drain
// - bit 1 gates output a level with the enable pin when set
// - bit 0 sets output a high or low
// - start-up step select: half millisecond steps or one millisecond steps
// - shutdown step select at bit 5: half or one millisecond steps
// - bit 4 makes shared pin output b or external clock input
// - bit 3 enables shared pin pull-down, in either pin function
// - bit 2 enables the enable pin pull-down
// - thermal warning threshold: 125 C when zero, 137 C when one
// - bit 0 turns spread spectrum on
// - pll enable: off uses rc oscillator, on uses external clock if present
// - with pll on, pulse an event on external clock appear or vanish
// - polarity bit 7: power-ok high or low when outputs valid
// - bit 6 picks power-ok drive: push-pull or open-drain
// - bit 4: undervoltage only, or over- and undervoltage checked
// - bit 1 includes regulator b in power-ok
// - bit 0 includes regulator a in power-ok
// - gated general outputs rise after their coded start-up delay from enable
`timescale 1ns/100ps
module pmic_cfg_bank #(
    parameter int STEP_CYCLES = pmic_cfg_pkg::DELAY_STEP_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_we,
    output logic [7:0] o_reg_rdata,
    input wire logic i_enable_pin,
    input wire logic i_ext_clock_present,
    input wire logic i_reg_a_uv_ok,
    input wire logic i_reg_a_ov_ok,
    input wire logic i_reg_b_uv_ok,
    input wire logic i_reg_b_ov_ok,
    input wire logic i_die_above_125,
    input wire logic i_die_above_137,
    input wire logic [3:0] i_out_a_start_code,
    input wire logic [3:0] i_out_a_stop_code,
    input wire logic [3:0] i_out_b_start_code,
    input wire logic [3:0] i_out_b_stop_code,
    output logic o_general_output_a,
    output logic o_general_output_a_oe_n,
    output logic o_general_output_b,
    output logic o_general_output_b_oe_n,
    output logic o_ext_clock_pin_is_clock,
    output logic o_shared_pin_pulldown,
    output logic o_enable_pin_pulldown,
    output logic o_thermal_warn,
    output logic o_spread_spectrum_on,
    output logic o_pll_on,
    output logic o_use_ext_clock,
    output logic [4:0] o_ext_clock_rate_code,
    output logic o_ext_clock_event,
    output logic o_power_ok_output,
    output logic o_power_ok_output_oe_n
);
    logic [7:0] gen_ctrl_q, gen_ctrl_d, setup_q, setup_d;
    logic [7:0] clk_ctrl_q, clk_ctrl_d, pok_ctrl_q, pok_ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    logic [6:0] sync_in, sync_out;
    logic en_s, clk_s, a_uv, a_ov, b_uv, b_ov, hot125, hot137;
    logic clk_seen_q, clk_seen_d, event_q, event_d;
    logic dly_a, dly_b;
    logic out_a_d, out_a_q, out_a_oen_d, out_a_oen_q;
    logic out_b_d, out_b_q, out_b_oen_d, out_b_oen_q;
    logic pok_d, pok_q, pok_oen_d, pok_oen_q, warn_d, warn_q;
    logic ok_a, ok_b, pok_valid;

    // every analog or pin status crosses into the clock domain here
    assign sync_in = {i_enable_pin, i_ext_clock_present, i_reg_a_uv_ok,
                      i_reg_a_ov_ok, i_reg_b_uv_ok, i_reg_b_ov_ok,
                      i_die_above_125};
    pin_sync #(.WIDTH(7)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(sync_in),
        .o_sync(sync_out)
    );
    pin_sync #(.WIDTH(1)) u_sync_hot (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_die_above_137),
        .o_sync(hot137)
    );
    assign {en_s, clk_s, a_uv, a_ov, b_uv, b_ov, hot125} = sync_out;

    // register writes; reserved output-control bits stay zero
    always_comb begin
        gen_ctrl_d = gen_ctrl_q;
        setup_d = setup_q;
        clk_ctrl_d = clk_ctrl_q;
        pok_ctrl_d = pok_ctrl_q;
        if (i_reg_we) begin
            case (i_reg_addr)
                pmic_cfg_pkg::GEN_OUT_CTRL_ADDR:
                    gen_ctrl_d = i_reg_wdata
                               & pmic_cfg_pkg::GEN_OUT_CTRL_WMASK;
                pmic_cfg_pkg::SETUP_ADDR: setup_d = i_reg_wdata;
                // reserved bit 5 is stored as written
                pmic_cfg_pkg::EXT_CLK_CTRL_ADDR: clk_ctrl_d = i_reg_wdata;
                pmic_cfg_pkg::POWER_OK_CTRL_ADDR: pok_ctrl_d = i_reg_wdata;
                default: ;
            endcase
        end
        case (i_reg_addr)
            pmic_cfg_pkg::GEN_OUT_CTRL_ADDR: rdata_d = gen_ctrl_q;
            pmic_cfg_pkg::SETUP_ADDR: rdata_d = setup_q;
            pmic_cfg_pkg::EXT_CLK_CTRL_ADDR: rdata_d = clk_ctrl_q;
            pmic_cfg_pkg::POWER_OK_CTRL_ADDR: rdata_d = pok_ctrl_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            gen_ctrl_q <= pmic_cfg_pkg::GEN_OUT_CTRL_RST;
            setup_q <= pmic_cfg_pkg::SETUP_RST;
            clk_ctrl_q <= pmic_cfg_pkg::EXT_CLK_CTRL_RST;
            pok_ctrl_q <= pmic_cfg_pkg::POWER_OK_CTRL_RST;
            rdata_q <= 8'h00;
        end else begin
            gen_ctrl_q <= gen_ctrl_d;
            setup_q <= setup_d;
            clk_ctrl_q <= clk_ctrl_d;
            pok_ctrl_q <= pok_ctrl_d;
            rdata_q <= rdata_d;
        end
    end
    assign o_reg_rdata = rdata_q;

    // enable pin delayed per output, step range from setup
    step_delay #(.STEP_CYCLES(STEP_CYCLES)) u_dly_a (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_target(en_s),
        .i_start_code(i_out_a_start_code),
        .i_stop_code(i_out_a_stop_code),
        .i_start_long(setup_q[pmic_cfg_pkg::START_STEP_BIT]),
        .i_stop_long(setup_q[pmic_cfg_pkg::STOP_STEP_BIT]),
        .o_level(dly_a)
    );
    step_delay #(.STEP_CYCLES(STEP_CYCLES)) u_dly_b (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_target(en_s),
        .i_start_code(i_out_b_start_code),
        .i_stop_code(i_out_b_stop_code),
        .i_start_long(setup_q[pmic_cfg_pkg::START_STEP_BIT]),
        .i_stop_long(setup_q[pmic_cfg_pkg::STOP_STEP_BIT]),
        .o_level(dly_b)
    );

    // pin drivers: open-drain releases on high, oe_n low means driving
    always_comb begin
        out_a_d = gen_ctrl_q[pmic_cfg_pkg::OUT_A_LEVEL_BIT];
        if (gen_ctrl_q[pmic_cfg_pkg::OUT_A_GATING_BIT]) begin
            out_a_d = out_a_d & dly_a;
        end
        out_a_oen_d = gen_ctrl_q[pmic_cfg_pkg::OUT_A_DRIVE_BIT]
                    & out_a_d;
        out_b_d = gen_ctrl_q[pmic_cfg_pkg::OUT_B_LEVEL_BIT];
        if (gen_ctrl_q[pmic_cfg_pkg::OUT_B_GATING_BIT]) begin
            out_b_d = out_b_d & dly_b;
        end
        out_b_oen_d = gen_ctrl_q[pmic_cfg_pkg::OUT_B_DRIVE_BIT]
                    & out_b_d;
        // as a clock input the shared pin is never driven
        if (setup_q[pmic_cfg_pkg::PIN_FUNCTION_BIT]) begin
            out_b_d = 1'b0;
            out_b_oen_d = 1'b1;
        end
        ok_a = a_uv
             & (a_ov | ~pok_ctrl_q[pmic_cfg_pkg::POK_WINDOW_BIT]);
        ok_b = b_uv
             & (b_ov | ~pok_ctrl_q[pmic_cfg_pkg::POK_WINDOW_BIT]);
        pok_valid =
            (ok_a | ~pok_ctrl_q[pmic_cfg_pkg::POK_SRC_A_BIT])
            & (ok_b | ~pok_ctrl_q[pmic_cfg_pkg::POK_SRC_B_BIT]);
        pok_d = pok_valid
              ^ pok_ctrl_q[pmic_cfg_pkg::POK_POLARITY_BIT];
        pok_oen_d = pok_ctrl_q[pmic_cfg_pkg::POK_DRIVE_BIT] & pok_d;
        warn_d = setup_q[pmic_cfg_pkg::THERMAL_LEVEL_BIT]
               ? hot137 : hot125;
        // edge of presence only counts while the pll is enabled
        clk_seen_d = clk_s;
        event_d = clk_ctrl_q[pmic_cfg_pkg::PLL_ENABLE_BIT]
                & (clk_s != clk_seen_q);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            out_a_q <= 1'b0;
            out_a_oen_q <= 1'b0;
            out_b_q <= 1'b0;
            out_b_oen_q <= 1'b0;
            pok_q <= 1'b0;
            pok_oen_q <= 1'b0;
            warn_q <= 1'b0;
            clk_seen_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            out_a_q <= out_a_d;
            out_a_oen_q <= out_a_oen_d;
            out_b_q <= out_b_d;
            out_b_oen_q <= out_b_oen_d;
            pok_q <= pok_d;
            pok_oen_q <= pok_oen_d;
            warn_q <= warn_d;
            clk_seen_q <= clk_seen_d;
            event_q <= event_d;
        end
    end

    assign o_general_output_a = out_a_q;
    assign o_general_output_a_oe_n = out_a_oen_q;
    assign o_general_output_b = out_b_q;
    assign o_general_output_b_oe_n = out_b_oen_q;
    assign o_power_ok_output = pok_q;
    assign o_power_ok_output_oe_n = pok_oen_q;
    assign o_thermal_warn = warn_q;
    assign o_ext_clock_event = event_q;
    assign o_ext_clock_pin_is_clock =
        setup_q[pmic_cfg_pkg::PIN_FUNCTION_BIT];
    assign o_shared_pin_pulldown =
        setup_q[pmic_cfg_pkg::SHARED_PD_BIT];
    assign o_enable_pin_pulldown =
        setup_q[pmic_cfg_pkg::ENABLE_PD_BIT];
    assign o_spread_spectrum_on = setup_q[pmic_cfg_pkg::SPREAD_BIT];
    assign o_pll_on = clk_ctrl_q[pmic_cfg_pkg::PLL_ENABLE_BIT];
    assign o_use_ext_clock = o_pll_on & clk_s;
    // reserved codes above the maximum are passed unchecked
    assign o_ext_clock_rate_code =
        clk_ctrl_q[pmic_cfg_pkg::RATE_CODE_MSB:pmic_cfg_pkg::RATE_CODE_LSB];

    property p_out_a_level;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        !gen_ctrl_q[pmic_cfg_pkg::OUT_A_GATING_BIT] |=>
            o_general_output_a == $past(gen_ctrl_q[0]);
    endproperty
    a_out_a_level: assert property (p_out_a_level)
        else $error("output a does not follow its level bit");

    property p_out_a_gate;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (gen_ctrl_q[pmic_cfg_pkg::OUT_A_GATING_BIT] && !dly_a) |=>
            !o_general_output_a;
    endproperty
    a_out_a_gate: assert property (p_out_a_gate)
        else $error("gated output a high while delayed enable low");

    property p_out_b_gate;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (!setup_q[pmic_cfg_pkg::PIN_FUNCTION_BIT]
         && gen_ctrl_q[pmic_cfg_pkg::OUT_B_GATING_BIT]) |=>
            o_general_output_b == ($past(gen_ctrl_q[4]) & $past(dly_b));
    endproperty
    a_out_b_gate: assert property (p_out_b_gate)
        else $error("gated output b is not level and enable");

    property p_out_a_od;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (gen_ctrl_q[pmic_cfg_pkg::OUT_A_DRIVE_BIT] && out_a_d) |=>
            o_general_output_a_oe_n;
    endproperty
    a_out_a_od: assert property (p_out_a_od)
        else $error("open-drain output a drives high");

    property p_clk_pin_free;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        setup_q[pmic_cfg_pkg::PIN_FUNCTION_BIT] |=> o_general_output_b_oe_n;
    endproperty
    a_clk_pin_free: assert property (p_clk_pin_free)
        else $error("shared pin driven while a clock input");

    property p_pok_value;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        1'b1 |=> o_power_ok_output
            == ($past(pok_valid) ^ $past(pok_ctrl_q[7]));
    endproperty
    a_pok_value: assert property (p_pok_value)
        else $error("power-ok level wrong for polarity");

    property p_pok_fail_a;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (pok_ctrl_q[pmic_cfg_pkg::POK_SRC_A_BIT] && !a_uv) |-> !pok_valid;
    endproperty
    a_pok_fail_a: assert property (p_pok_fail_a)
        else $error("power-ok valid with failing selected regulator a");

    property p_clk_event;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (o_pll_on && $changed(clk_s)) |=> o_ext_clock_event;
    endproperty
    a_clk_event: assert property (p_clk_event)
        else $error("no event on external clock change");

    property p_no_event_off;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        !o_pll_on |=> !o_ext_clock_event;
    endproperty
    a_no_event_off: assert property (p_no_event_off)
        else $error("clock event raised with pll disabled");

    property p_warn_sel;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (setup_q[pmic_cfg_pkg::THERMAL_LEVEL_BIT] && hot137)
            |=> o_thermal_warn;
    endproperty
    a_warn_sel: assert property (p_warn_sel)
        else $error("high threshold warning missed");
endmodule

// ===== test/host_model.sv
// host side model: pin pull-ups and sampling of the bank's outputs
`timescale 1ns/100ps
module host_model (
    input wire logic i_sys_clk,
    input wire logic i_out_a,
    input wire logic i_out_a_oe_n,
    input wire logic i_out_b,
    input wire logic i_out_b_oe_n,
    input wire logic i_shared_pd,
    input wire logic i_pok,
    input wire logic i_pok_oe_n,
    output logic o_out_a_seen,
    output logic o_out_b_seen,
    output logic o_pok_seen
);
    // released lines go to the host pull-up; the shared pin pull-down wins
    // since the host resistor is the weaker one
    always_ff @(posedge i_sys_clk) begin
        o_out_a_seen <= i_out_a_oe_n ? 1'b1 : i_out_a;
        o_out_b_seen <= i_out_b_oe_n ? ~i_shared_pd : i_out_b;
        o_pok_seen <= i_pok_oe_n ? 1'b1 : i_pok;
    end
endmodule

// ===== test/testbench.sv
// self-checking bench for the output, clock pin and power-ok bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    mismatches++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module testbench;
    localparam int S = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic we = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic en = 1'b0;
    logic pres = 1'b0;
    logic [3:0] ok = 4'h0; // b ov, b uv, a ov, a uv
    logic [1:0] hot = 2'h0; // above 137, above 125
    logic [3:0] sc = 4'h0;
    logic [3:0] pc = 4'h0;
    logic ga, ga_n, gb, gb_n, isclk, spd, epd;
    logic tw, ss, pll, use_ext, ev, pk, pk_n;
    logic [4:0] rate;
    logic a_seen, b_seen, pk_seen;
    logic [31:0] seed = 32'h0000_0FDD;
    int mismatches = 0;
    int tests_run = 0;

    pmic_cfg_bank #(.STEP_CYCLES(S)) dut_u (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_we(we), .o_reg_rdata(rdata),
        .i_enable_pin(en), .i_ext_clock_present(pres),
        .i_reg_a_uv_ok(ok[0]), .i_reg_a_ov_ok(ok[1]),
        .i_reg_b_uv_ok(ok[2]), .i_reg_b_ov_ok(ok[3]),
        .i_die_above_125(hot[0]), .i_die_above_137(hot[1]),
        .i_out_a_start_code(sc), .i_out_a_stop_code(pc),
        .i_out_b_start_code(sc), .i_out_b_stop_code(pc),
        .o_general_output_a(ga), .o_general_output_a_oe_n(ga_n),
        .o_general_output_b(gb), .o_general_output_b_oe_n(gb_n),
        .o_ext_clock_pin_is_clock(isclk), .o_shared_pin_pulldown(spd),
        .o_enable_pin_pulldown(epd), .o_thermal_warn(tw),
        .o_spread_spectrum_on(ss), .o_pll_on(pll),
        .o_use_ext_clock(use_ext), .o_ext_clock_rate_code(rate),
        .o_ext_clock_event(ev), .o_power_ok_output(pk),
        .o_power_ok_output_oe_n(pk_n)
    );

    host_model host_u (
        .i_sys_clk(clk), .i_out_a(ga), .i_out_a_oe_n(ga_n),
        .i_out_b(gb), .i_out_b_oe_n(gb_n), .i_shared_pd(spd),
        .i_pok(pk), .i_pok_oe_n(pk_n), .o_out_a_seen(a_seen),
        .o_out_b_seen(b_seen), .o_pok_seen(pk_seen)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic exp_gen(input logic lvl, gate, en_d);
        return lvl & (~gate | en_d);
    endfunction

    function automatic logic exp_pok(input logic [7:0] c, input logic [3:0] v);
        logic a_ok;
        logic b_ok;
        a_ok = v[0] & (~c[4] | v[1]);
        b_ok = v[2] & (~c[4] | v[3]);
        return c[7] ^ ((a_ok | ~c[0]) & (b_ok | ~c[1]));
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // strobe dropped with a spare cycle so calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        step(1);
        we = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        step(1);
        d = rdata;
    endtask

    task automatic done(input string s);
        $display("test done: %s", s);
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic count_ev(output int n);
        n = 0;
        repeat (12) begin
            step(1);
            if (ev === 1'b1) n++;
        end
    endtask

    // sync latency allowed on top of the coded delay
    task automatic meas(input logic v, input int lo);
        int n;
        n = 0;
        while (ga !== v && n < 300) begin
            step(1);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            final_report();
        end
        `CHK("delay", 1'b1, n >= lo && n <= lo + 10)
    endtask

    initial begin
        logic [31:0] r;
        logic [7:0] a, d, c;
        logic [11:0] corner [4];
        int n, lo;
        corner = '{12'hF13, 12'h713, 12'hE03, 12'h000};
        step(10);
        rst = 1'b0;
        step(1);
        for (int i = 0; i < 4; i++) begin
            rd(8'h12 + 8'(i), d);
            `CHK("reset value", 8'h00, d)
        end
        for (int i = 0; i < 32; i++) begin
            a = 8'h12 + 8'(i % 4);
            r = rnd();
            d = r[7:0];
            if (a == 8'h14) d = {d[7:6], 1'b0, 5'(d[4:0] % 24)};
            wr(a, d);
            wr(8'h11, ~d);
            rd(a, c);
            `CHK("readback", a == 8'h12 ? d & 8'h77 : d, c)
            if (a == 8'h13) begin
                `CHK("pin function", d[4], isclk)
                `CHK("shared pull-down", d[3], spd)
                `CHK("enable pull-down", d[2], epd)
                `CHK("spread", d[0], ss)
                if (d[4]) begin
                    `CHK("b released", 1'b1, gb_n)
                    `CHK("b pulled", ~d[3], b_seen)
                end
            end
            if (a == 8'h14) begin
                `CHK("pll on", d[6], pll)
                `CHK("rate code", d[4:0], rate)
            end
        end
        rd(8'h20, c);
        `CHK("unmapped", 8'h00, c)
        done("registers");
        wr(8'h13, 8'h00);
        for (int i = 0; i < 16; i++) begin
            c = {1'b0, 3'(i), 1'b0, 3'(i)};
            en = i[3];
            wr(8'h12, c);
            step(12);
            `CHK("out a", exp_gen(c[0], c[1], en), a_seen)
            `CHK("out a oe_n", c[2] & exp_gen(c[0], c[1], en), ga_n)
            `CHK("out b", exp_gen(c[4], c[5], en), b_seen)
            `CHK("out b oe_n", c[6] & exp_gen(c[4], c[5], en), gb_n)
        end
        done("general outputs");
        for (int i = 0; i < 8; i++) begin
            hot = 2'(i);
            wr(8'h13, {6'h00, i[2], 1'b0});
            step(8);
            `CHK("thermal", i[2] ? hot[1] : hot[0], tw)
        end
        done("thermal");
        for (int i = 0; i < 28; i++) begin
            r = rnd();
            if (i < 4) r[11:0] = corner[i];
            ok = r[11:8];
            c = r[7:0] & 8'hD3;
            wr(8'h15, c);
            step(8);
            `CHK("power ok", exp_pok(c, ok), pk_seen)
            `CHK("power ok oe_n", c[6] & exp_pok(c, ok), pk_n)
        end
        done("power ok");
        wr(8'h14, 8'h00);
        pres = 1'b1;
        count_ev(n);
        `CHK("event pll off", 0, n)
        `CHK("ext clock pll off", 1'b0, use_ext)
        pres = 1'b0;
        step(8);
        wr(8'h14, 8'h57); // top legal rate, reserved bit zero
        pres = 1'b1;
        count_ev(n);
        `CHK("event appear", 1, n)
        `CHK("ext clock", 1'b1, use_ext)
        pres = 1'b0;
        count_ev(n);
        `CHK("event vanish", 1, n)
        done("pll");
        // enable still high from earlier tests; drop it so the rise is timed
        en = 1'b0;
        wr(8'h12, 8'h03);
        step(12);
        for (int k = 0; k < 4; k++) begin
            sc = k[0] ? 4'hF : 4'h1;
            pc = sc;
            wr(8'h13, {1'b0, k[1], (k[0] ^ k[1]), 5'h00});
            lo = int'(sc) * S * (k[1] ? 2 : 1);
            en = 1'b1;
            meas(1'b1, lo);
            lo = int'(pc) * S * ((k[0] ^ k[1]) ? 2 : 1);
            en = 1'b0;
            meas(1'b0, lo);
        end
        done("delays");
        final_report();
    end
endmodule
